//--- sp0_pkg.sv
package sp0_pkg;

	// register map
	localparam logic [7:0] ADDR_CONTROL = 8'h98;
	localparam logic [7:0] ADDR_DATA = 8'h99;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h9a;

	// values after reset
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] MASK_RESET = 2'h0;

	// operating modes, {mode_high, mode_low}
	localparam logic [1:0] MODE_SYNC = 2'h0;
	localparam logic [1:0] MODE_TIMER_10 = 2'h1;
	localparam logic [1:0] MODE_FIXED_11 = 2'h2;
	localparam logic [1:0] MODE_TIMER_11 = 2'h3;

	// bit periods in core clocks
	localparam int M0_SLOW_CLKS = 12;
	localparam int M0_FAST_CLKS = 4;
	localparam int M2_SLOW_CLKS = 64;
	localparam int M2_FAST_CLKS = 32;
	localparam int OVERSAMPLE = 16;

	// divider reloads derived from the periods above
	localparam logic [5:0] M0_SLOW_HALF = 6'(M0_SLOW_CLKS / 2);
	localparam logic [5:0] M0_FAST_HALF = 6'(M0_FAST_CLKS / 2);
	localparam logic [5:0] M2_SLOW_TICK = 6'(M2_SLOW_CLKS / OVERSAMPLE);
	localparam logic [5:0] M2_FAST_TICK = 6'(M2_FAST_CLKS / OVERSAMPLE);

	// frame positions and sample points
	localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] IDX_NINTH = 4'h9;
	localparam logic [3:0] IDX_STOP11 = 4'ha;
	localparam logic [3:0] SYNC_LAST = 4'h7;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_ASYNC = 3'b010,
		TX_SYNC = 3'b100
	} sp0_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_BITS = 2'b10
	} sp0_rx_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sp0_bus_t;

	typedef struct packed {
		logic mode_high_or_frame_error;
		logic mode_low_select;
		logic third_select_multiproc;
		logic receive_enable;
		logic transmit_ninth_bit;
		logic receive_ninth_bit;
		logic transmit_complete_flag;
		logic receive_complete_flag;
	} sp0_ctrl_t;

endpackage

//--- sp0_tick_div.sv
`timescale 1ns/100ps
`default_nettype none

// free-running divider, one-cycle tick every i_count clocks
module sp0_tick_div #(
	parameter int W = 6
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic [W-1:0] i_count,
	output logic o_tick
);

	logic [W-1:0] cnt;

	// clear realigns the phase to a frame start
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= '0;
			o_tick <= 1'b0;
		end else if (i_clear) begin
			cnt <= W'(i_count - 1'b1);
			o_tick <= 1'b0;
		end else if (cnt == '0) begin
			cnt <= W'(i_count - 1'b1);
			o_tick <= 1'b1;
		end else begin
			cnt <= W'(cnt - 1'b1);
			o_tick <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- sp0_uart.sv
// Summary of operation
// - mode bits select mode; mode 0 12/4 clocks
// - modes 1/3: 10/11-bit frames, timer rate
// - mode 2: 11-bit frame, 64/32 clocks
// - bit 7: mode select or framing error
// - with select set, bit 7 writes flag only
// - mode bit and error flag stored apart
// - mode 1 multiproc: bad stop drops frame
// - modes 2/3 multiproc: need ninth bit one
// - receive enable gates receiver, starts mode 0
// - modes 2/3 send transmit ninth bit
// - receive ninth bit: ninth or stop bit
// - transmit flag after last data bit
// - receive flag timing per mode
// - data location: write tx, read rx
// - one interrupt from flags and enable; each flag is also gated by its irq_mask bit, which resets to 0
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module sp0_uart (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire sp0_pkg::sp0_bus_t i_bus,
	output logic [7:0] o_rdata,
	input wire logic i_frame_error_select,
	input wire logic i_rate_doubling_bit,
	input wire logic i_port0_interrupt_enable,
	input wire logic i_baud_tick,
	input wire logic i_rxd,
	output logic o_rxd,
	output logic o_rxd_oe,
	output logic o_txd,
	output logic o_irq
);

	// control register storage
	logic mode_high;
	logic fe_flag;
	logic mode_low;
	logic third_sel;
	logic rx_en;
	logic tx_ninth;
	logic rx_ninth;
	logic tx_flag;
	logic rx_flag;
	logic [1:0] irq_mask;
	logic [7:0] rx_hold;
	sp0_pkg::sp0_ctrl_t ctrl_view;

	// engine state
	sp0_pkg::sp0_tx_state_t tx_state;
	sp0_pkg::sp0_rx_state_t rx_state;
	logic [10:0] tx_sr;
	logic [3:0] tx_idx;
	logic [3:0] tx_sub;
	logic sync_rx;
	logic [7:0] s_word;
	logic [7:0] rx_sr;
	logic [3:0] rx_idx;
	logic [3:0] rx_sub;
	logic [1:0] votes;
	logic [7:0] a_word;
	logic rxd_meta;
	logic rxd_sync;

	// event pulses, one cycle each, and the held ninth bit value
	logic ev_tx;
	logic ev_srx;
	logic ev_arx;
	logic ev_fe;
	logic ev_ninth;
	logic ninth_val;

	logic [1:0] mode;
	logic wr_ctrl;
	logic wr_data;
	logic wr_mask;
	logic [5:0] div_count;
	logic div_tick;
	logic async_tick;
	logic start_async;
	logic start_sync;
	logic start_srx;
	logic [3:0] tx_last;
	logic vote;
	logic accept;

	// mode bit kept apart from error flag
	assign mode = {mode_high, mode_low};
	assign wr_ctrl = i_bus.wr && (i_bus.addr == sp0_pkg::ADDR_CONTROL);
	assign wr_data = i_bus.wr && (i_bus.addr == sp0_pkg::ADDR_DATA);
	assign wr_mask = i_bus.wr && (i_bus.addr == sp0_pkg::ADDR_IRQ_MASK);

	// mode 0 half period from third select
	// mode 2 tick: sixteenth of 64 or 32
	always_comb begin
		if (mode == sp0_pkg::MODE_SYNC) begin
			div_count = third_sel ? sp0_pkg::M0_FAST_HALF :
				sp0_pkg::M0_SLOW_HALF;
		end else begin
			div_count = i_rate_doubling_bit ? sp0_pkg::M2_FAST_TICK :
				sp0_pkg::M2_SLOW_TICK;
		end
	end

	// timer modes run on the external 16x tick
	assign async_tick = (mode == sp0_pkg::MODE_FIXED_11) ? div_tick :
		i_baud_tick;

	// data write only starts an idle engine
	assign start_async = wr_data && (tx_state == sp0_pkg::TX_IDLE) &&
		(mode != sp0_pkg::MODE_SYNC);
	// mode 0 reception waits for a clear flag
	assign start_srx = !wr_data && (tx_state == sp0_pkg::TX_IDLE) &&
		(mode == sp0_pkg::MODE_SYNC) && rx_en && !rx_flag && !ev_srx;
	assign start_sync = (tx_state == sp0_pkg::TX_IDLE) &&
		(mode == sp0_pkg::MODE_SYNC) && (wr_data || start_srx);

	// ten bits in mode 1, eleven otherwise
	assign tx_last = (mode == sp0_pkg::MODE_TIMER_10) ? sp0_pkg::IDX_NINTH :
		sp0_pkg::IDX_STOP11;

	// majority of three mid-bit samples rejects glitches
	assign vote = (votes[1] & votes[0]) | (votes[1] & rxd_sync) |
		(votes[0] & rxd_sync);

	// multiproc needs a one in the ninth slot
	// mode 1 multiproc drops a bad stop bit
	assign accept = !(third_sel && !vote);

	sp0_tick_div #(
		.W(6)
	) u_div (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_clear(start_sync),
		.i_count(div_count),
		.o_tick(div_tick)
	);

	// two-flop synchroniser on the receive pin
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
		end else begin
			rxd_meta <= i_rxd;
			rxd_sync <= rxd_meta;
		end
	end

	// transmitter and mode 0 shift engine
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_state <= sp0_pkg::TX_IDLE;
			tx_sr <= '0;
			tx_idx <= '0;
			tx_sub <= '0;
			sync_rx <= 1'b0;
			s_word <= '0;
			o_txd <= 1'b1;
			o_rxd <= 1'b1;
			o_rxd_oe <= 1'b0;
			ev_tx <= 1'b0;
			ev_srx <= 1'b0;
		end else begin
			ev_tx <= 1'b0;
			ev_srx <= 1'b0;
			case (tx_state)
				sp0_pkg::TX_IDLE: begin
					tx_idx <= '0;
					tx_sub <= '0;
					// ninth slot: tb8 in 2/3, stop in 1
					if (start_async) begin
						// start bit waits for the next tick so it
						// lasts a full bit; stop comes from the fill in 2/3
						tx_sr <= {(mode == sp0_pkg::MODE_TIMER_10) |
							tx_ninth, i_bus.wdata, 2'b00};
						tx_idx <= '1;
						tx_sub <= sp0_pkg::SUB_LAST;
						tx_state <= sp0_pkg::TX_ASYNC;
					end else if (start_sync) begin
						// write wins over a pending reception
						tx_sr <= {3'h0, i_bus.wdata};
						sync_rx <= !wr_data;
						o_rxd_oe <= wr_data;
						tx_state <= sp0_pkg::TX_SYNC;
					end
				end
				sp0_pkg::TX_ASYNC: begin
					if (async_tick) begin
						tx_sub <= 4'(tx_sub + 1'b1);
						if (tx_sub == sp0_pkg::SUB_LAST) begin
							if (tx_idx == tx_last) begin
								tx_state <= sp0_pkg::TX_IDLE;
							end else begin
								tx_idx <= 4'(tx_idx + 1'b1);
								tx_sr <= {1'b1, tx_sr[10:1]};
								o_txd <= tx_sr[1];
								// flag as the stop bit begins
								if (4'(tx_idx + 1'b1) == tx_last) begin
									ev_tx <= 1'b1;
								end
							end
						end
					end
				end
				sp0_pkg::TX_SYNC: begin
					// clock low half drives data, rising edge samples
					if (div_tick) begin
						if (o_txd) begin
							o_txd <= 1'b0;
							if (!sync_rx) begin
								o_rxd <= tx_sr[0];
							end
						end else begin
							o_txd <= 1'b1;
							tx_sr <= {3'h0, rxd_sync, tx_sr[7:1]};
							tx_idx <= 4'(tx_idx + 1'b1);
							// mode 0: end of eighth bit
							// mode 0 receive after eighth bit
							if (tx_idx == sp0_pkg::SYNC_LAST) begin
								tx_state <= sp0_pkg::TX_IDLE;
								o_rxd_oe <= 1'b0;
								o_rxd <= 1'b1;
								s_word <= {rxd_sync, tx_sr[7:1]};
								ev_srx <= sync_rx;
								ev_tx <= !sync_rx;
							end
						end
					end
				end
				default: begin
					tx_state <= sp0_pkg::TX_IDLE;
					o_txd <= 1'b1;
					o_rxd_oe <= 1'b0;
				end
			endcase
		end
	end

	// asynchronous receiver, 16x oversampled
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_state <= sp0_pkg::RX_IDLE;
			rx_sr <= '0;
			rx_idx <= '0;
			rx_sub <= '0;
			votes <= '0;
			a_word <= '0;
			ev_arx <= 1'b0;
			ev_fe <= 1'b0;
			ev_ninth <= 1'b0;
			ninth_val <= 1'b0;
		end else begin
			ev_arx <= 1'b0;
			ev_fe <= 1'b0;
			ev_ninth <= 1'b0;
			case (rx_state)
				sp0_pkg::RX_IDLE: begin
					rx_idx <= '0;
					rx_sub <= '0;
					if (rx_en && (mode != sp0_pkg::MODE_SYNC) &&
						!rxd_sync) begin
						rx_state <= sp0_pkg::RX_BITS;
					end
				end
				sp0_pkg::RX_BITS: begin
					if (!rx_en || (mode == sp0_pkg::MODE_SYNC)) begin
						rx_state <= sp0_pkg::RX_IDLE;
					end else if (async_tick) begin
						rx_sub <= 4'(rx_sub + 1'b1);
						if (rx_sub >= sp0_pkg::SAMPLE_A &&
							rx_sub < sp0_pkg::SAMPLE_C) begin
							votes <= {votes[0], rxd_sync};
						end
						if (rx_sub == sp0_pkg::SUB_LAST) begin
							rx_idx <= 4'(rx_idx + 1'b1);
						end
						if (rx_sub == sp0_pkg::SAMPLE_C) begin
							if (rx_idx == '0) begin
								// false start: line back high
								if (vote) begin
									rx_state <= sp0_pkg::RX_IDLE;
								end
							end else if (rx_idx < sp0_pkg::IDX_NINTH) begin
								rx_sr <= {vote, rx_sr[7:1]};
							end else if (rx_idx == sp0_pkg::IDX_NINTH) begin
								// flag after stop or ninth sample
								a_word <= rx_sr;
								ev_arx <= accept;
								// ninth bit, or stop bit in mode 1
								ev_ninth <= accept &&
									!((mode == sp0_pkg::MODE_TIMER_10) &&
									third_sel);
								ninth_val <= vote;
								if (mode == sp0_pkg::MODE_TIMER_10) begin
									// bad stop bit raises the error
									ev_fe <= !vote;
									rx_state <= sp0_pkg::RX_IDLE;
								end
							end else begin
								ev_fe <= !vote;
								rx_state <= sp0_pkg::RX_IDLE;
							end
						end
					end
				end
				default: begin
					rx_state <= sp0_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// control bits; hardware set beats software clear
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			{mode_high, mode_low, third_sel, rx_en, tx_ninth, rx_ninth,
				tx_flag, rx_flag} <= sp0_pkg::CONTROL_RESET;
			fe_flag <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				mode_low <= i_bus.wdata[6];
				third_sel <= i_bus.wdata[5];
				rx_en <= i_bus.wdata[4];
				tx_ninth <= i_bus.wdata[3];
			end
			// error select steers bit 7 to the flag
			if (wr_ctrl && !i_frame_error_select) begin
				mode_high <= i_bus.wdata[7];
			end
			if (ev_fe) begin
				fe_flag <= 1'b1;
			end else if (wr_ctrl && i_frame_error_select &&
				i_bus.wdata[7]) begin
				fe_flag <= 1'b0;
			end
			if (ev_ninth) begin
				rx_ninth <= ninth_val;
			end else if (wr_ctrl) begin
				rx_ninth <= i_bus.wdata[2];
			end
			// only software clears, by writing one
			if (ev_tx) begin
				tx_flag <= 1'b1;
			end else if (wr_ctrl && i_bus.wdata[1]) begin
				tx_flag <= 1'b0;
			end
			if (ev_srx || ev_arx) begin
				rx_flag <= 1'b1;
			end else if (wr_ctrl && i_bus.wdata[0]) begin
				rx_flag <= 1'b0;
			end
		end
	end

	// receive holding register, read side only
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_hold <= sp0_pkg::DATA_RESET;
		end else if (ev_srx) begin
			rx_hold <= s_word;
		end else if (ev_arx) begin
			rx_hold <= a_word;
		end
	end

	// interrupt mask register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_mask <= sp0_pkg::MASK_RESET;
		end else if (wr_mask) begin
			irq_mask <= i_bus.wdata[1:0];
		end
	end

	// bit 7 reads the flag when selected
	always_comb begin
		ctrl_view.mode_high_or_frame_error = i_frame_error_select ?
			fe_flag : mode_high;
		ctrl_view.mode_low_select = mode_low;
		ctrl_view.third_select_multiproc = third_sel;
		ctrl_view.receive_enable = rx_en;
		ctrl_view.transmit_ninth_bit = tx_ninth;
		ctrl_view.receive_ninth_bit = rx_ninth;
		ctrl_view.transmit_complete_flag = tx_flag;
		ctrl_view.receive_complete_flag = rx_flag;
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				sp0_pkg::ADDR_CONTROL: o_rdata <= ctrl_view;
				sp0_pkg::ADDR_DATA: o_rdata <= rx_hold;
				sp0_pkg::ADDR_IRQ_MASK: o_rdata <= {6'h0, irq_mask};
				default: o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// one level request from either flag
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= i_port0_interrupt_enable &&
				|({tx_flag, rx_flag} & irq_mask);
		end
	end

endmodule

`default_nettype wire

//--- sp0_uart_chk.sv
`timescale 1ns/100ps
`default_nettype none

module sp0_uart_chk (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire sp0_pkg::sp0_bus_t i_bus,
	input wire logic [7:0] o_rdata,
	input wire logic i_frame_error_select,
	input wire logic i_rate_doubling_bit,
	input wire logic i_port0_interrupt_enable,
	input wire logic o_rxd_oe,
	input wire logic o_txd,
	input wire logic o_irq
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	logic mode_hi, mode_lo, third, ctrl_wr, ctrl_rd, map_rd;
	logic [9:0] lo_cnt;
	int per;

	// mode shadow; bit 7 is left alone while it is the error flag
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_hi <= 1'b0;
			mode_lo <= 1'b0;
			third <= 1'b0;
		end else if (ctrl_wr) begin
			mode_hi <= i_frame_error_select ? mode_hi : i_bus.wdata[7];
			mode_lo <= i_bus.wdata[6];
			third <= i_bus.wdata[5];
		end
	end

	// length of the running low phase on the send line
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			lo_cnt <= 10'h000;
		end else begin
			lo_cnt <= o_txd ? 10'h000 : lo_cnt + 10'h001;
		end
	end

	// decoded bus cycles and the mode 2 bit period
	assign ctrl_wr = i_bus.wr && i_bus.addr == sp0_pkg::ADDR_CONTROL;
	assign ctrl_rd = i_bus.rd && i_bus.addr == sp0_pkg::ADDR_CONTROL;
	assign map_rd = i_bus.addr >= sp0_pkg::ADDR_CONTROL &&
		i_bus.addr <= sp0_pkg::ADDR_IRQ_MASK;
	assign per = i_rate_doubling_bit ? sp0_pkg::M2_FAST_CLKS :
		sp0_pkg::M2_SLOW_CLKS;

	rdata_idle_a:
		assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	unmapped_zero_a:
		assert property (i_bus.rd && !map_rd |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	mask_upper_a:
		assert property (i_bus.rd && i_bus.addr == sp0_pkg::ADDR_IRQ_MASK
			|=> o_rdata[7:2] == 6'h00)
		else $error("mask upper bits set");
	ctrl_store_a:
		assert property ((ctrl_wr && !i_frame_error_select) ##1 !i_bus.wr
			##1 (ctrl_rd && !i_frame_error_select)
			|=> o_rdata[7:3] == $past(i_bus.wdata[7:3], 3))
		else $error("control bits not kept");
	irq_enable_a:
		assert property (!i_port0_interrupt_enable |=> !o_irq)
		else $error("irq while disabled");
	sync_half_a:
		assert property (!mode_hi && !mode_lo && $rose(o_txd)
			|-> lo_cnt == (third ? 10'h002 : 10'h006))
		else $error("shift clock low phase wrong");
	fixed_period_a:
		assert property (mode_hi && !mode_lo && $rose(o_txd)
			|-> int'(lo_cnt) % per == 0)
		else $error("mode 2 bit length wrong");
	oe_sync_only_a:
		assert property (o_rxd_oe |-> !mode_hi && !mode_lo)
		else $error("data pin driven outside mode 0");

	// main scenarios reached
	cover property (o_rxd_oe && $rose(o_txd));
	cover property ($rose(o_irq));
	cover property (mode_hi && !mode_lo && $rose(o_txd));
endmodule

bind sp0_uart sp0_uart_chk i_sp0_uart_chk (
	.i_core_clk(i_core_clk),
	.i_rst(i_rst),
	.i_bus(i_bus),
	.o_rdata(o_rdata),
	.i_frame_error_select(i_frame_error_select),
	.i_rate_doubling_bit(i_rate_doubling_bit),
	.i_port0_interrupt_enable(i_port0_interrupt_enable),
	.o_rxd_oe(o_rxd_oe),
	.o_txd(o_txd),
	.o_irq(o_irq)
);
`default_nettype wire

//--- sp0_node.sv
`timescale 1ns/100ps
`default_nettype none

// remote node: drives the receive line, listens on the send line
module sp0_node (
	input wire logic i_core_clk,
	input wire logic i_txd,
	output logic o_line
);
	initial o_line = 1'b1;

	// frame bits go out first bit first
	// line rests high between frames, as an idle line must
	task automatic send(input logic [10:0] bits, input int n, input int per);
		@(posedge i_core_clk);
		for (int i = 0; i < n; i++) begin
			o_line <= bits[i];
			repeat (per) @(posedge i_core_clk);
		end
		o_line <= 1'b1;
	endtask

	// bounded wait for a start bit, then mid-bit samples
	task automatic capture(output logic [10:0] bits, input int n,
		input int per);
		int w;
		w = 0;
		bits = 11'h7ff;
		while (i_txd !== 1'b0 && w < 3000) begin
			@(posedge i_core_clk);
			w++;
		end
		repeat (per / 2) @(posedge i_core_clk);
		for (int i = 0; i < n; i++) begin
			bits[i] = i_txd;
			repeat (per) @(posedge i_core_clk);
		end
	endtask

	// mode 0 slave: next bit after each fall of the shift clock
	// slow rate only, the pin synchroniser eats the fast half period
	task automatic shift_out(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			for (int w = 0; w < 100 && i_txd !== 1'b0; w++) begin
				@(posedge i_core_clk);
			end
			o_line <= d[i];
			for (int w = 0; w < 100 && i_txd !== 1'b1; w++) begin
				@(posedge i_core_clk);
			end
		end
		o_line <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	localparam logic [7:0] CTL = sp0_pkg::ADDR_CONTROL;
	localparam logic [7:0] DAT = sp0_pkg::ADDR_DATA;
	localparam logic [7:0] MSK = sp0_pkg::ADDR_IRQ_MASK;
	logic clk = 1'b0;
	logic rst = 1'b1;
	sp0_pkg::sp0_bus_t bus = 18'h00000;
	logic fe_sel = 1'b0;
	logic dbl = 1'b0;
	logic ien = 1'b0;
	logic tick = 1'b0;
	logic [7:0] rdata;
	logic rxd_out, rxd_oe, txd, irq, line, pin;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;

	// clock, and a timer overflow stand-in ticking every second clock
	always #5 clk = ~clk;
	always @(posedge clk) tick <= ~tick;
	// shared data pin: the block wins while it drives
	assign pin = rxd_oe ? rxd_out : line;

	sp0_uart i_sp0_uart (
		.i_core_clk(clk),
		.i_rst(rst),
		.i_bus(bus),
		.o_rdata(rdata),
		.i_frame_error_select(fe_sel),
		.i_rate_doubling_bit(dbl),
		.i_port0_interrupt_enable(ien),
		.i_baud_tick(tick),
		.i_rxd(pin),
		.o_rxd(rxd_out),
		.o_rxd_oe(rxd_oe),
		.o_txd(txd),
		.o_irq(irq)
	);
	sp0_node i_sp0_node (
		.i_core_clk(clk),
		.i_txd(txd),
		.o_line(line)
	);

	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop;
		end
	end

	task automatic chk(input logic [10:0] g, input logic [10:0] e, string m);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, string m);
		@(posedge clk);
		bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk({3'h0, rdata}, {3'h0, e}, m);
	endtask
	task automatic irq_is(input logic en, input logic e, string m);
		@(posedge clk);
		ien <= en;
		repeat (2) @(posedge clk);
		#1 chk({10'h000, irq}, {10'h000, e}, m);
	endtask
	task automatic wait_txd(input logic lvl);
		for (int w = 0; w < 500 && txd !== lvl; w++) begin
			@(posedge clk);
		end
	endtask

	task automatic t_regs;
		rdc(CTL, 8'h00, "control reset");
		rdc(DAT, 8'h00, "data reset");
		rdc(MSK, 8'h00, "mask reset");
		rdc(8'h9b, 8'h00, "unmapped");
		wr(MSK, 8'hff);
		rdc(MSK, 8'h03, "mask bits");
		wr(CTL, 8'hec);
		rdc(CTL, 8'hec, "control store");
		wr(CTL, 8'h00);
		$display("regs done");
	endtask

	// mode 0 send; data checked in each low half of the shift clock
	task automatic t_sync;
		logic [7:0] d;
		d = 8'h3c;
		for (int t = 0; t < 2; t++) begin
			wr(CTL, {2'b00, t[0], 5'h00});
			wr(DAT, d);
			for (int i = 0; i < 8; i++) begin
				wait_txd(1'b0);
				chk({9'h000, rxd_oe, rxd_out}, {9'h001, d[i]}, "sync bit");
				wait_txd(1'b1);
			end
			rdc(CTL, {2'b00, t[0], 5'h02}, "sync tx flag");
			wr(CTL, {2'b00, t[0], 5'h02});
		end
		$display("sync done");
	endtask

	// mode 0 reception started by the enable bit alone
	task automatic t_srx;
		wr(CTL, 8'h10);
		i_sp0_node.shift_out(8'h6a);
		rdc(CTL, 8'h11, "sync rx flag");
		rdc(DAT, 8'h6a, "sync rx data");
		wr(CTL, 8'h01);
		$display("sync rx done");
	endtask

	// mode 2 send at both rates, second write lands while busy
	task automatic t_m2tx;
		logic [10:0] v;
		wr(MSK, 8'h03);
		for (int d = 0; d < 2; d++) begin
			@(posedge clk);
			dbl <= d[0];
			wr(CTL, {4'h8, ~d[0], 3'h0});
			wr(DAT, 8'ha5);
			wr(DAT, 8'h00);
			i_sp0_node.capture(v, 11, d ? 32 : 64);
			chk(v, {1'b1, ~d[0], 8'ha5, 1'b0}, "m2 frame");
			chk({10'h000, txd}, 11'h001, "busy write");
			rdc(CTL, {4'h8, ~d[0], 3'h2}, "tx flag");
			irq_is(1'b1, 1'b1, "tx irq");
			irq_is(1'b0, 1'b0, "irq gated");
			wr(CTL, {4'h8, ~d[0], 3'h2});
			irq_is(1'b1, 1'b0, "irq cleared");
		end
		$display("m2 tx done");
	endtask

	// mode 2 receive with address filtering on
	task automatic t_m2rx;
		@(posedge clk);
		dbl <= 1'b0;
		wr(CTL, 8'hb0);
		i_sp0_node.send({2'b10, 8'h5a, 1'b0}, 11, 64);
		rdc(CTL, 8'hb0, "ninth zero");
		i_sp0_node.send({2'b11, 8'h96, 1'b0}, 11, 64);
		rdc(CTL, 8'hb5, "ninth one");
		rdc(DAT, 8'h96, "rx data");
		irq_is(1'b1, 1'b1, "rx irq");
		$display("m2 rx done");
	endtask

	// mode 1 on timer ticks: disabled, bad stop, good frame
	task automatic t_m1;
		wr(CTL, 8'h41);
		i_sp0_node.send({2'b01, 8'h3c, 1'b0}, 10, 32);
		rdc(CTL, 8'h40, "rx off");
		rdc(DAT, 8'h96, "rx off data");
		wr(CTL, 8'h70);
		@(posedge clk);
		fe_sel <= 1'b1;
		i_sp0_node.send({2'b00, 8'hc3, 1'b0}, 10, 32);
		rdc(CTL, 8'hf0, "bad stop");
		wr(CTL, 8'hf0);
		rdc(CTL, 8'h70, "error cleared");
		@(posedge clk);
		fe_sel <= 1'b0;
		rdc(CTL, 8'h70, "mode kept");
		wr(CTL, 8'h50);
		i_sp0_node.send({2'b01, 8'h3c, 1'b0}, 10, 32);
		rdc(CTL, 8'h55, "stop bit kept");
		rdc(DAT, 8'h3c, "m1 data");
		$display("m1 done");
	endtask

	// timer-rate sends: mode 1 ten bits, mode 3 eleven bits
	task automatic t_timer_tx;
		logic [10:0] v;
		for (int m = 0; m < 2; m++) begin
			wr(CTL, {m[0], 3'b100, m[0], 3'b001});
			wr(DAT, 8'h69);
			i_sp0_node.capture(v, m ? 11 : 10, 32);
			chk(v, {2'b11, 8'h69, 1'b0}, "timer frame");
			rdc(CTL, {m[0], 3'b100, m[0], 3'b010}, "timer flag");
			wr(CTL, {m[0], 3'b100, m[0], 3'b010});
		end
		$display("timer tx done");
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// reset for three clocks, then the scenarios in turn
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_sync;
		t_srx;
		t_m2tx;
		t_m2rx;
		t_m1;
		t_timer_tx;
		report_and_stop;
	end
endmodule
`default_nettype wire
